/* include/bcrc_pkg.sv */
// Constants, field layout and register index helpers for the banked CPU register block
// Operation
// - A 5-bit register address selects one of 32 locations R0 to R31.
// - The processor reaches 44 eight-bit registers through the banked location space.
// - R0-R11 form banked groups A and B, one bank per group visible.
// - Exchange picks main or alternate A at R0-R3, B at R4-R11.
// - Exchange takes two T-states, sets any bank pair, optionally changes interrupt enable.
// - Reset selects the alternate bank for both groups.
// - Immediate-operand writes reach only R0-R15; others reach all 32 locations.
// - R12-R31 are unbanked general registers; alternate B has eight at R4-R11.
// - R8 of the visible B bank is the second operand; written only as destination.
// - Transceiver clock select picks oscillator, its divisions, or external clock.
// - CPU clock runs at oscillator rate or half; each period is one T-state.
// - Clock output always carries the undivided oscillator clock.
// - Clock output disable bit tri-states the clock output pin.
// - Separate two-bit instruction and three-bit data wait-state fields.
// - Reset loads 3 instruction and 7 data wait states.
// - Vector base supplies the high vector byte; resets to 00h.
// - With base at reset value the nonmaskable vector is 001Ch.
// - Each maskable interrupt is gated by its mask bit and the global enable.
// - Direction bit makes the bidirectional pin input or output; mask 3 masks or drives.
// - The remote interface control register is absent from the processor space.
package bcrc_pkg;
    localparam int NUM_PHYS = 44;
    localparam int IDX_W = 6;
    // Locations
    localparam logic [4:0] LOC_BANK_B_LO = 5'h04;
    localparam logic [4:0] LOC_BANK_B_HI = 5'h0b;
    localparam logic [4:0] LOC_ACC = 5'h08;
    localparam logic [4:0] LOC_DEV_CFG = 5'h00;
    localparam logic [4:0] LOC_VEC_BASE = 5'h01;
    localparam logic [4:0] LOC_INT_MASK = 5'h02;
    localparam logic [4:0] LOC_AUX_CTL = 5'h03;
    // Physical storage layout
    localparam logic [5:0] PHYS_ALT_A = 6'h04;
    localparam logic [5:0] PHYS_MAIN_B = 6'h04;
    localparam logic [5:0] PHYS_ALT_B = 6'h0c;
    localparam logic [5:0] PHYS_UNBANKED = 6'h0c;
    localparam logic [5:0] PHYS_DEV_CFG = 6'h04;
    localparam logic [5:0] PHYS_VEC_BASE = 6'h05;
    localparam logic [5:0] PHYS_INT_MASK = 6'h06;
    localparam logic [5:0] PHYS_AUX_CTL = 6'h07;
    // Device configuration fields
    localparam int DCR_CCS = 7;
    localparam int DCR_TCS_LSB = 5;
    localparam int DCR_IW_LSB = 3;
    localparam int DCR_DW_LSB = 0;
    localparam logic [1:0] IW_RESET = 2'h3;
    localparam logic [2:0] DW_RESET = 3'h7;
    localparam logic [7:0] DCR_RESET = {1'b0, 2'h0, IW_RESET, DW_RESET};
    localparam logic [7:0] VEC_BASE_RESET = 8'h00;
    // Aux control fields
    localparam int ACR_GIE = 0;
    localparam int ACR_BIC = 1;
    localparam int ACR_COD = 2;
    localparam int NUM_IRQ = 5;
    localparam int BIDIR_INT_REQUEST_IDX = 3;
    localparam logic [7:0] NMI_VEC_LO = 8'h1c;
    // Transceiver clock selections
    localparam logic [1:0] TCS_OSC = 2'h0;
    localparam logic [1:0] TCS_DIV2 = 2'h1;
    localparam logic [1:0] TCS_DIV4 = 2'h2;
    localparam logic [1:0] TCS_EXT = 2'h3;
    // Exchange interrupt option and timing
    localparam logic [1:0] EXX_INT_KEEP = 2'h0;
    localparam logic [1:0] EXX_INT_ON = 2'h1;
    localparam logic [1:0] EXX_INT_OFF = 2'h2;
    localparam logic [1:0] EXX_TSTATES = 2'h2;
    // APB map
    localparam logic [7:0] APB_LOC_LAST = 8'h7c;
    localparam logic [7:0] APB_STATUS = 8'h80;

    function automatic logic [5:0] bcrc_phys(input logic [4:0] loc, input logic alt_a,
                                             input logic alt_b);
        logic [5:0] l;
        l = {1'b0, loc};
        if (loc < LOC_BANK_B_LO) begin
            return alt_a ? l + PHYS_ALT_A : l;
        end
        if (loc <= LOC_BANK_B_HI) begin
            return alt_b ? l + PHYS_ALT_B : l + PHYS_MAIN_B;
        end
        return l + PHYS_UNBANKED;
    endfunction
endpackage

/* include/bcrc_ctl_if.sv */
// Configuration fields passed from the register array to the clock and interrupt units
interface bcrc_ctl_if;
    logic cpu_clock_select;
    logic [1:0] tcs;
    logic global_int_enable;
    logic bidir_int_direction;
    logic [4:0] masks;
    modport src (output cpu_clock_select, tcs, global_int_enable, bidir_int_direction, masks);
    modport clk (input cpu_clock_select, tcs);
    modport irq (input global_int_enable, bidir_int_direction, masks);
endinterface

/* hw/bcrc_clkgen.sv */
// T-state strobe and transceiver clock strobe generation from the oscillator clock
module bcrc_clkgen
    import bcrc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    bcrc_ctl_if.clk ctl,
    input wire logic ext_xcvr_clock_in,
    output logic tstate_tick,
    output logic xcvr_clock_tick
);
    logic half_phase;
    logic [1:0] div_cnt;
    logic ext_ff1, ext_ff2, ext_ff3;
    logic next_tick;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_phase <= 1'b0;
        end else begin
            half_phase <= ~half_phase;
        end
    end
    assign tstate_tick = ~ctl.cpu_clock_select | half_phase;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_ff1 <= 1'b0;
            ext_ff2 <= 1'b0;
            ext_ff3 <= 1'b0;
        end else begin
            ext_ff1 <= ext_xcvr_clock_in;
            ext_ff2 <= ext_ff1;
            ext_ff3 <= ext_ff2;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 2'h0;
        end else begin
            div_cnt <= div_cnt + 2'h1;
        end
    end

    always_comb begin
        unique case (ctl.tcs)
            TCS_OSC: next_tick = 1'b1;
            TCS_DIV2: next_tick = div_cnt[0];
            TCS_DIV4: next_tick = &div_cnt;
            TCS_EXT: next_tick = ext_ff2 & ~ext_ff3;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xcvr_clock_tick <= 1'b0;
        end else begin
            xcvr_clock_tick <= next_tick;
        end
    end

    a_half_rate: assert property (@(posedge pclk) disable iff (!presetn)
        ctl.cpu_clock_select && $stable(ctl.cpu_clock_select) && tstate_tick |=> !tstate_tick || !ctl.cpu_clock_select)
        else $error("CPU clock not halved");
endmodule

/* hw/bcrc_intgate.sv */
// Maskable interrupt gating and bidirectional interrupt pin control
module bcrc_intgate
    import bcrc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    bcrc_ctl_if.irq ctl,
    input wire logic [NUM_IRQ-1:0] int_src,
    input wire logic bidir_int_request_n_in,
    output logic bidir_int_request_n_out,
    output logic bidir_int_request_n_oe_n,
    output logic [NUM_IRQ-1:0] int_pending
);
    logic bidir_int_request_ff1, bidir_int_request_ff2;
    logic [NUM_IRQ-1:0] req;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bidir_int_request_ff1 <= 1'b1;
            bidir_int_request_ff2 <= 1'b1;
        end else begin
            bidir_int_request_ff1 <= bidir_int_request_n_in;
            bidir_int_request_ff2 <= bidir_int_request_ff1;
        end
    end

    // Pin only counts as a source while it is an input
    always_comb begin
        req = int_src;
        req[BIDIR_INT_REQUEST_IDX] = ~ctl.bidir_int_direction & ~bidir_int_request_ff2;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_pending <= '0;
        end else begin
            int_pending <= req & ctl.masks & {NUM_IRQ{ctl.global_int_enable}};
        end
    end

    assign bidir_int_request_n_oe_n = ~ctl.bidir_int_direction;
    assign bidir_int_request_n_out = ~ctl.masks[BIDIR_INT_REQUEST_IDX];

    a_pending_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !ctl.global_int_enable |=> int_pending == '0)
        else $error("Interrupt pending while globally disabled");
    a_bidir_int_request_drive: assert property (@(posedge pclk) disable iff (!presetn)
        ctl.bidir_int_direction |-> !bidir_int_request_n_oe_n
            && bidir_int_request_n_out == !ctl.masks[BIDIR_INT_REQUEST_IDX])
        else $error("Bidirectional pin not driven from mask bit");
endmodule

/* hw/bcrc_top.sv */
// Banked CPU register file with timing, control and interrupt configuration
//
// The register addresses and the APB slave port were chosen for this implementation.
module bcrc_top
    import bcrc_pkg::*;
#(
    parameter int NUM_REGS = NUM_PHYS
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [4:0] cpu_src_addr,
    output logic [7:0] cpu_src_data,
    output logic [7:0] cpu_acc_data,
    input wire logic cpu_wr_en,
    input wire logic cpu_imm,
    input wire logic [4:0] cpu_dst_addr,
    input wire logic [7:0] cpu_wr_data,
    input wire logic bank_exchange_instr,
    input wire logic exx_main_a,
    input wire logic exx_main_b,
    input wire logic [1:0] exx_int_op,
    output logic exx_busy,
    output logic exx_done,
    output logic bank_alt_a,
    output logic bank_alt_b,
    output logic [1:0] instr_wait_select,
    output logic [2:0] data_wait_select,
    output logic [15:0] nmi_vector,
    output logic tstate_tick,
    output logic xcvr_clock_tick,
    input wire logic ext_xcvr_clock_in,
    output logic clk_out,
    output logic clk_out_oe_n,
    input wire logic [NUM_IRQ-1:0] int_src,
    output logic [NUM_IRQ-1:0] int_pending,
    input wire logic bidir_int_request_n_in,
    output logic bidir_int_request_n_out,
    output logic bidir_int_request_n_oe_n
);
    logic [7:0] regs [NUM_REGS];
    logic [1:0] exx_cnt;
    logic exx_take;
    logic [4:0] eff_dst;
    logic [5:0] dst_idx;
    logic apb_setup, apb_access;
    logic apb_loc_hit, apb_stat_hit;
    logic apb_wr;
    logic [5:0] apb_idx;
    logic [7:0] device_config_reg;
    logic [7:0] aux_control_reg;
    logic [7:0] interrupt_mask_reg;
    logic [7:0] vector_base_reg;

    bcrc_ctl_if ctl ();

    ////////////////////////////////////////////////////////////////////////////
    // Location decode

    // Immediate forms carry only four address bits
    assign eff_dst = cpu_imm ? {1'b0, cpu_dst_addr[3:0]} : cpu_dst_addr;
    // Five address bits map through the bank selects onto 44 stored bytes
    assign dst_idx = bcrc_phys(eff_dst, bank_alt_a, bank_alt_b);
    // Remote interface control has no location in this space
    assign apb_idx = bcrc_phys(paddr[6:2], bank_alt_a, bank_alt_b);

    // Dual-port reads: source and accumulator both see the visible banks
    assign cpu_src_data = regs[bcrc_phys(cpu_src_addr, bank_alt_a, bank_alt_b)];
    assign cpu_acc_data = regs[bcrc_phys(LOC_ACC, bank_alt_a, bank_alt_b)];

    ////////////////////////////////////////////////////////////////////////////
    // Bank exchange

    assign exx_take = bank_exchange_instr & ~exx_busy;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank_alt_a <= 1'b1;
            bank_alt_b <= 1'b1;
        end else if (exx_take) begin
            // New selects are visible at the very next edge
            bank_alt_a <= ~exx_main_a;
            bank_alt_b <= ~exx_main_b;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exx_busy <= 1'b0;
            exx_cnt <= 2'h0;
            exx_done <= 1'b0;
        end else begin
            exx_done <= 1'b0;
            if (exx_take) begin
                exx_busy <= 1'b1;
                exx_cnt <= 2'h0;
            end else if (exx_busy && tstate_tick) begin
                if (exx_cnt == EXX_TSTATES - 2'h1) begin
                    exx_busy <= 1'b0;
                    exx_done <= 1'b1;
                end
                exx_cnt <= exx_cnt + 2'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register array

    assign apb_setup = psel & ~penable;
    assign apb_access = psel & penable;
    assign apb_loc_hit = (paddr <= APB_LOC_LAST) && (paddr[1:0] == 2'h0);
    assign apb_stat_hit = (paddr == APB_STATUS);
    // CPU writes take the array port; APB writes stall while cpu_wr_en is high
    assign pready = ~(pwrite & cpu_wr_en);
    assign apb_wr = apb_access & pwrite & pready & apb_loc_hit & pstrb[0];
    assign pslverr = apb_access & ~apb_loc_hit & ~apb_stat_hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs[i] <= 8'h00;
            end
            regs[PHYS_DEV_CFG] <= DCR_RESET;
            regs[PHYS_VEC_BASE] <= VEC_BASE_RESET;
        end else begin
            // Only the addressed byte and, on an exchange, the GIE bit change; other hidden bytes keep their data
            if (cpu_wr_en) begin
                regs[dst_idx] <= cpu_wr_data;
            end else if (apb_wr) begin
                regs[apb_idx] <= pwdata[7:0];
            end
            if (exx_take && exx_int_op == EXX_INT_ON) begin
                regs[PHYS_AUX_CTL][ACR_GIE] <= 1'b1;
            end else if (exx_take && exx_int_op == EXX_INT_OFF) begin
                regs[PHYS_AUX_CTL][ACR_GIE] <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (apb_setup && !pwrite) begin
            if (paddr <= APB_LOC_LAST && paddr[1:0] == 2'h0) begin
                prdata <= {24'h00_0000, regs[apb_idx]};
            end else if (paddr == APB_STATUS) begin
                prdata <= {28'h000_0000, aux_control_reg[ACR_GIE], exx_busy,
                           bank_alt_b, bank_alt_a};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration fields

    // Configuration always lives in alternate A, whichever bank is visible
    assign device_config_reg = regs[PHYS_DEV_CFG];
    assign vector_base_reg = regs[PHYS_VEC_BASE];
    assign interrupt_mask_reg = regs[PHYS_INT_MASK];
    assign aux_control_reg = regs[PHYS_AUX_CTL];

    assign instr_wait_select = device_config_reg[DCR_IW_LSB +: 2];
    assign data_wait_select = device_config_reg[DCR_DW_LSB +: 3];
    assign nmi_vector = {vector_base_reg, NMI_VEC_LO};

    assign ctl.cpu_clock_select = device_config_reg[DCR_CCS];
    assign ctl.tcs = device_config_reg[DCR_TCS_LSB +: 2];
    assign ctl.global_int_enable = aux_control_reg[ACR_GIE];
    assign ctl.bidir_int_direction = aux_control_reg[ACR_BIC];
    assign ctl.masks = interrupt_mask_reg[NUM_IRQ-1:0];

    // Clock output is the oscillator itself, never the divided CPU clock
    assign clk_out = pclk;
    assign clk_out_oe_n = aux_control_reg[ACR_COD];

    bcrc_clkgen u_clkgen (
        .pclk(pclk),
        .presetn(presetn),
        .ctl(ctl.clk),
        .ext_xcvr_clock_in(ext_xcvr_clock_in),
        .tstate_tick(tstate_tick),
        .xcvr_clock_tick(xcvr_clock_tick)
    );

    bcrc_intgate u_intgate (
        .pclk(pclk),
        .presetn(presetn),
        .ctl(ctl.irq),
        .int_src(int_src),
        .bidir_int_request_n_in(bidir_int_request_n_in),
        .bidir_int_request_n_out(bidir_int_request_n_out),
        .bidir_int_request_n_oe_n(bidir_int_request_n_oe_n),
        .int_pending(int_pending)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_exx_take;
        bank_exchange_instr && !exx_busy;
    endsequence

    sequence s_exx_finish;
        exx_busy [*1] ##[1:4] exx_done;
    endsequence

    a_exx_banks: assert property (@(posedge pclk) disable iff (!presetn)
        s_exx_take |=> bank_alt_a == !$past(exx_main_a)
            && bank_alt_b == !$past(exx_main_b))
        else $error("Bank selects not updated by exchange");

    a_exx_two_tstates: assert property (@(posedge pclk) disable iff (!presetn)
        s_exx_take |=> s_exx_finish)
        else $error("Exchange did not finish in two T-states");

    a_exx_gie: assert property (@(posedge pclk) disable iff (!presetn)
        s_exx_take and (exx_int_op == EXX_INT_OFF) |=> !ctl.global_int_enable)
        else $error("Exchange did not disable interrupts");

    a_reset_state: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(presetn) |-> bank_alt_a && bank_alt_b && instr_wait_select == IW_RESET
            && data_wait_select == DW_RESET && nmi_vector == 16'h001c)
        else $error("Wrong state after reset release");

    a_acc_operand: assert property (@(posedge pclk) disable iff (!presetn)
        cpu_src_addr == LOC_ACC |-> cpu_src_data == cpu_acc_data)
        else $error("Accumulator read path differs from source path");

    a_imm_low_only: assert property (@(posedge pclk) disable iff (!presetn)
        cpu_wr_en && cpu_imm && cpu_dst_addr[4] && !bank_exchange_instr
            |=> regs[bcrc_phys($past(cpu_dst_addr), bank_alt_a, bank_alt_b)]
                == $past(regs[bcrc_phys(cpu_dst_addr, bank_alt_a, bank_alt_b)]))
        else $error("Immediate write reached an upper location");

    a_hidden_keep: assert property (@(posedge pclk) disable iff (!presetn)
        bank_alt_a && !bank_exchange_instr |=> $stable(regs[0]))
        else $error("Hidden main A register changed");

    a_clkout_tristate: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(aux_control_reg[ACR_COD]) |-> clk_out_oe_n ##1 clk_out_oe_n
            || !aux_control_reg[ACR_COD])
        else $error("Clock output not released when disabled");

    a_apb_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && paddr > APB_STATUS |-> pslverr && pready)
        else $error("Unmapped APB address not flagged");
endmodule

/* verif/bcrc_cpu_model.sv */
// Processor core model issuing register writes and bank exchanges
module bcrc_cpu_model (
    input wire logic pclk,
    input wire logic exx_done,
    output logic cpu_wr_en,
    output logic cpu_imm,
    output logic [4:0] cpu_dst_addr,
    output logic [7:0] cpu_wr_data,
    output logic bank_exchange_instr,
    output logic exx_main_a,
    output logic exx_main_b,
    output logic [1:0] exx_int_op
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cpu_wr_en = 1'b0;
        cpu_imm = 1'b0;
        cpu_dst_addr = 5'h00;
        cpu_wr_data = 8'h00;
        bank_exchange_instr = 1'b0;
        exx_main_a = 1'b0;
        exx_main_b = 1'b0;
        exx_int_op = 2'h0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cpu_write(input logic [4:0] a, input logic [7:0] d, input logic imm);
        @(posedge pclk);
        cpu_wr_en <= 1'b1;
        cpu_imm <= imm;
        cpu_dst_addr <= a;
        cpu_wr_data <= d;
        @(posedge pclk);
        cpu_wr_en <= 1'b0;
    endtask
    // Returns cycles from take to done; the next exchange waits for done
    task automatic exchange(input logic ma, input logic mb, input logic [1:0] op, output int n);
        @(posedge pclk);
        bank_exchange_instr <= 1'b1;
        exx_main_a <= ma;
        exx_main_b <= mb;
        exx_int_op <= op;
        @(posedge pclk);
        bank_exchange_instr <= 1'b0;
        #1;
        n = 0;
        while (exx_done !== 1'b1 && n < 20) begin
            @(posedge pclk);
            #1;
            n++;
        end
    endtask
endmodule

/* verif/banked_cpu_register_control_tb.sv */
// Self-checking bench for the banked CPU register block
module banked_cpu_register_control_tb
    import bcrc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, v, m, rb [2][32];
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [3:0] pstrb = 4'hf;
    logic [4:0] cpu_src_addr = 5'h00, int_src = 5'h00, cpu_dst_addr, int_pending;
    logic [7:0] cpu_src_data, cpu_acc_data, cpu_wr_data;
    logic cpu_wr_en, cpu_imm, bank_exchange_instr, exx_main_a, exx_main_b, exx_busy, exx_done;
    logic [1:0] exx_int_op, instr_wait_select;
    logic [1:0] ops [4] = '{2'h1, 2'h2, 2'h0, 2'h1};
    logic [2:0] data_wait_select, ec = 3'h0;
    logic [15:0] nmi_vector;
    logic bank_alt_a, bank_alt_b, tstate_tick, xcvr_clock_tick, clk_out, clk_out_oe_n;
    logic bidir_int_request_n_out, bidir_int_request_n_oe_n, pslverr, pready, rerr, g;
    logic pin_drv = 1'b1, ext_run = 1'b0;
    wire logic bidir_int_request_n_in, ext_xcvr_clock_in;
    int fails = 0, tests_run = 0, n, ts, xs;
    // Bench drives the pin from pin_drv while the DUT output is off
    assign bidir_int_request_n_in = bidir_int_request_n_oe_n ? pin_drv : bidir_int_request_n_out;
    assign ext_xcvr_clock_in = ec[2];
    always #2 pclk = ~pclk;
    always @(posedge pclk) ec <= ext_run ? ec + 3'h1 : 3'h0;
    bcrc_top dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .cpu_src_addr, .cpu_src_data, .cpu_acc_data, .cpu_wr_en, .cpu_imm,
        .cpu_dst_addr, .cpu_wr_data, .bank_exchange_instr, .exx_main_a, .exx_main_b,
        .exx_int_op, .exx_busy, .exx_done, .bank_alt_a, .bank_alt_b, .instr_wait_select,
        .data_wait_select, .nmi_vector, .tstate_tick, .xcvr_clock_tick, .ext_xcvr_clock_in,
        .clk_out, .clk_out_oe_n, .int_src, .int_pending, .bidir_int_request_n_in,
        .bidir_int_request_n_out, .bidir_int_request_n_oe_n);
    bcrc_cpu_model cpu (.pclk, .exx_done, .cpu_wr_en, .cpu_imm, .cpu_dst_addr, .cpu_wr_data,
        .bank_exchange_instr, .exx_main_a, .exx_main_b, .exx_int_op);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        if (fails == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            fails++;
            conclude();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic xchg(input logic ma, input logic mb, input logic [1:0] op);
        cpu.exchange(ma, mb, op, n);
        if (n >= 20) begin
            fails++;
            conclude();
        end
    endtask
    task automatic crd(input int a);
        @(posedge pclk);
        cpu_src_addr <= a[4:0];
        #1;
    endtask
    task automatic count();
        ts = 0;
        xs = 0;
        repeat (32) begin
            @(posedge pclk);
            #1;
            ts += tstate_tick;
            xs += xcvr_clock_tick;
        end
    endtask
    function automatic logic [4:0] irq_exp(input logic [4:0] s, input logic [4:0] mk,
                                           input logic ge, input logic p);
        logic [4:0] e;
        e = s;
        e[3] = !p;
        return ge ? e & mk : 5'h00;
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h409c2944));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk("bank_alt_a", 1, bank_alt_a);
        chk("bank_alt_b", 1, bank_alt_b);
        chk("instr_wait", 3, instr_wait_select);
        chk("data_wait", 7, data_wait_select);
        chk("nmi_vector", 32'h1c, nmi_vector);
        apb(0, 8'h00, 0);
        chk("config", 32'h1f, rdat);
        apb(1, 8'h80, 0);
        apb(0, 8'h80, 0);
        chk("status", 32'h3, rdat);
        apb(0, 8'h84, 0);
        chk("unmapped", 1, rerr);
        apb(0, 8'h7c, 0);
        chk("last_loc", 0, rerr);
        v = $urandom;
        apb(1, 8'h04, {24'h0, v});
        #1;
        chk("nmi_vector", {16'h0, v, 8'h1c}, nmi_vector);
        for (int k = 0; k < 2; k++) begin
            if (k == 1) xchg(1'b0, 1'b1, EXX_INT_KEEP);
            chk("bank_alt_b", k == 0, bank_alt_b);
            chk("acc", 0, cpu_acc_data);
            for (int l = 4; l < 28; l++) begin
                rb[k][l] = $urandom;
                if (l < 12 || l > 19) cpu.cpu_write(l[4:0], rb[k][l], 1'b0);
            end
        end
        for (int k = 0; k < 2; k++) begin
            xchg(1'b0, k[0], EXX_INT_KEEP);
            for (int l = 4; l < 28; l++) begin
                if (l < 12 || l > 19) begin
                    crd(l);
                    chk("src", rb[l < 12 ? k : 1][l], cpu_src_data);
                end
            end
            chk("acc", rb[k][8], cpu_acc_data);
        end
        v = $urandom;
        cpu.cpu_write(5'h15, v, 1'b1);
        crd(5);
        chk("imm_dst", v, cpu_src_data);
        crd(21);
        chk("imm_far", rb[1][21], cpu_src_data);
        g = 1'b0;
        for (int c = 3; c >= 0; c--) begin
            xchg(c[0], c[1], ops[c]);
            if (ops[c] == EXX_INT_ON) g = 1'b1;
            if (ops[c] == EXX_INT_OFF) g = 1'b0;
            chk("exx_cycles", 2, n);
            apb(0, 8'h80, 0);
            chk("status", {g, 1'b0, !c[1], !c[0]}, rdat);
        end
        v = $urandom;
        apb(1, 8'h00, {27'h0, v[4:0]});
        #1;
        chk("instr_wait", v[4:3], instr_wait_select);
        chk("data_wait", v[2:0], data_wait_select);
        for (int s = 0; s < 4; s++) begin
            apb(1, 8'h00, {25'h0, s[1:0], 5'h1f});
            ext_run <= (s == 3);
            count();
            chk("xcvr_ticks", 1, xs >= (32 >> s) - 1 && xs <= (32 >> s) + 1);
            chk("tstate_ticks", 32, ts);
        end
        apb(1, 8'h00, 32'h9f);
        count();
        chk("tstate_half", 16, ts);
        xchg(1'b0, 1'b0, EXX_INT_KEEP);
        chk("exx_half", 1, n >= 2 && n <= 4);
        apb(1, 8'h00, 32'h1f);
        #1;
        chk("clk_out_hi", pclk, clk_out);
        @(negedge pclk);
        #1;
        chk("clk_out_lo", pclk, clk_out);
        apb(1, 8'h0c, 32'h4);
        #1;
        chk("clk_out_oe_n", 1, clk_out_oe_n);
        for (int i = 0; i < 6; i++) begin
            m = $urandom;
            g = $urandom;
            apb(1, 8'h08, {24'h0, m});
            apb(1, 8'h0c, {31'h0, g});
            int_src <= $urandom;
            pin_drv <= $urandom;
            repeat (5) @(posedge pclk);
            #1;
            chk("pin_oe_n", 1, bidir_int_request_n_oe_n);
            chk("pending", irq_exp(int_src, m[4:0], g, pin_drv), int_pending);
        end
        chk("clk_out_oe_n", 0, clk_out_oe_n);
        apb(1, 8'h0c, 32'h2);
        #1;
        chk("pin_oe_n", 0, bidir_int_request_n_oe_n);
        chk("pin_out", !m[3], bidir_int_request_n_out);
        conclude();
    end
endmodule
